//--- hdl/ramp_pkg.sv
// Purpose: Shared types and constants for the automatic frequency ramp generator.
// Assumes: One 20 MHz clock standing in for the phase detector clock.
// Notes:   Field encodings follow the ramp programming fields.
package ramp_pkg;

  // Field widths
  localparam int NUM_W   = 34;   // Numerator accumulator, signed, covers +/-2^33
  localparam int INC_W   = 30;   // Segment increment, two's complement
  localparam int LEN_W   = 16;   // Segment length count
  localparam int RPT_W   = 13;   // Repeat count

  // Advance and repeat-event codes
  localparam logic [1:0] ADV_TIMEOUT = 2'h0;
  localparam logic [1:0] ADV_TRIG_A  = 2'h1;
  localparam logic [1:0] ADV_TRIG_B  = 2'h2;

  // Trigger source codes
  localparam logic [3:0] TRG_OFF      = 4'h0;
  localparam logic [3:0] TRG_CLK_RISE = 4'h1;
  localparam logic [3:0] TRG_DIR_RISE = 4'h2;
  localparam logic [3:0] TRG_ALWAYS   = 4'h4;
  localparam logic [3:0] TRG_CLK_FALL = 4'h9;
  localparam logic [3:0] TRG_DIR_FALL = 4'hA;

  // Reset values and unit increments
  localparam logic [NUM_W-1:0] NUM_RESET = 34'h0;
  localparam logic [LEN_W-1:0] LEN_ZERO  = 16'h0;
  localparam logic [RPT_W-1:0] RPT_ZERO  = 13'h0;
  localparam logic [LEN_W-1:0] LEN_ONE   = 16'h1;
  localparam logic [RPT_W-1:0] RPT_ONE   = 13'h1;

  // Settings of one segment
  typedef struct packed {
    logic [LEN_W-1:0] length;      // Ramp clocks in the segment
    logic [INC_W-1:0] increment;   // Signed step per ramp clock
    logic             successor;   // Next segment index
    logic [1:0]       advance;     // Advance condition code
    logic             restore;     // Reload numerator at segment end
  } segment_cfg_t;

  // Global ramp settings
  typedef struct packed {
    logic             ramp_enable;     // Master enable
    logic             pin_mode;        // 1 selects pin stepping, not automatic
    logic             clock_halve;     // Ramp clock is half detector rate
    logic             cal_per_segment; // Recalibrate at each segment change
    logic [3:0]       trig_a_src;      // Trigger A source code
    logic [3:0]       trig_b_src;      // Trigger B source code
    logic [RPT_W-1:0] repeat_count;    // Pattern repeats, 0 means endless
    logic [1:0]       repeat_event;    // Repeat counter event code
    logic [NUM_W-1:0] cal_threshold;   // Numerator move forcing recalibration
    logic [NUM_W-1:0] limit_low;       // Signed low clamp
    logic [NUM_W-1:0] limit_high;      // Signed high clamp
  } ramp_cfg_t;

  // Generator states
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_CAL} ramp_state_t;

endpackage : ramp_pkg

//--- hdl/ramp_generator.sv
// Purpose: Automatic two-segment frequency ramp generator stepping the fraction numerator.
// Assumes: The ref_clk stands for the phase detector clock; calibration is done outside.
// Notes:   Step pins are asynchronous and pass a three-stage synchroniser.
//          Repeat events are counted in the run state only, separately from segment changes.

module ramp_generator
(
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     reset,
  // Configuration
  input  wire ramp_pkg::ramp_cfg_t      cfg,
  input  wire ramp_pkg::segment_cfg_t   seg0,
  input  wire ramp_pkg::segment_cfg_t   seg1,
  input  wire logic [ramp_pkg::NUM_W-1:0] start_numerator,
  input  wire logic                     cal_start,
  // External step pins
  input  wire logic                     step_clock_pin,
  input  wire logic                     step_direction_pin,
  // Calibration handshake
  input  wire logic                     cal_done,
  output logic                          cal_request,
  // Status and numerator
  output logic [ramp_pkg::NUM_W-1:0]    numerator,
  output logic                          ramp_active,
  output logic                          current_segment
);
  import ramp_pkg::*;

  // Trigger decode, shared by both trigger selectors
  // Edge inputs last a single clock, so an edge trigger fires exactly once; TRG_ALWAYS fires every clock
  function automatic logic trig_fire(input logic [3:0] src, input logic cr, input logic cf,
                                     input logic dr, input logic df);
    case (src)
      TRG_CLK_RISE: trig_fire = cr;
      TRG_DIR_RISE: trig_fire = dr;
      TRG_ALWAYS:   trig_fire = 1'b1;
      TRG_CLK_FALL: trig_fire = cf;
      TRG_DIR_FALL: trig_fire = df;
      default:      trig_fire = 1'b0; // Disabled and invalid codes never fire
    endcase
  endfunction : trig_fire

  // Event select, shared by advance and repeat decoding
  // Reserved codes mean never, so a bad setting stalls rather than races
  function automatic logic event_sel(input logic [1:0] code, input logic tmo,
                                     input logic ta, input logic tb);
    case (code)
      ADV_TIMEOUT: event_sel = tmo;
      ADV_TRIG_A:  event_sel = ta;
      ADV_TRIG_B:  event_sel = tb;
      default:     event_sel = 1'b0; // Reserved code never fires
    endcase
  endfunction : event_sel

  // Signed clamp of the numerator
  // Both limits are compared as signed values, so negative bounds work
  function automatic logic [NUM_W-1:0] clamp(input logic signed [NUM_W-1:0] v,
                                             input logic signed [NUM_W-1:0] lo,
                                             input logic signed [NUM_W-1:0] hi);
    // Values inside the window pass unchanged
    if (v < lo)
      clamp = lo;
    else if (v > hi)
      clamp = hi;
    else
      clamp = v;
  endfunction : clamp

  // Pin synchronisers, three stages each
  // Three stages keep metastable values away from the edge logic
  logic [2:0] clk_sync_q, clk_sync_d; // Step clock pin stages
  logic [2:0] dir_sync_q, dir_sync_d; // Step direction pin stages
  logic       clk_lvl_q,  clk_lvl_d;  // Accepted step clock level
  logic       dir_lvl_q,  dir_lvl_d;  // Accepted direction level
  logic       clk_rise, clk_fall, dir_rise, dir_fall;

  // Ramp state
  // Counter width matches the longest programmable segment
  ramp_state_t        state_q,   state_d;   // Sequencer state
  logic               seg_q,     seg_d;     // Active segment
  logic [LEN_W-1:0]   count_q,   count_d;   // Ramp clocks spent in segment
  logic [RPT_W-1:0]   rpt_q,     rpt_d;     // Repeat events seen
  logic [NUM_W-1:0]   num_q,     num_d;     // Running numerator
  logic [NUM_W-1:0]   origin_q,  origin_d;  // Numerator when ramping began
  logic [NUM_W-1:0]   cal_ref_q, cal_ref_d; // Numerator at last calibration
  logic               phase_q,   phase_d;   // Halving toggle
  logic               creq_q,    creq_d;    // Calibration request level

  // Working signals
  // step_sum is the raw next value before the limits are applied
  segment_cfg_t       seg;
  logic               auto_mode, tick, trig_a, trig_b, timeout, advance, rpt_event;
  logic signed [NUM_W-1:0] step_sum, moved;
  logic [NUM_W-1:0]   abs_moved;

  // Synchroniser next values; edges read stages two and three only
  // Stage one only feeds stage two; nothing else may look at it
  always_comb
  begin
    clk_sync_d = {clk_sync_q[1:0], step_clock_pin};
    dir_sync_d = {dir_sync_q[1:0], step_direction_pin};
    // A change counts once the later two stages agree
    clk_lvl_d  = (clk_sync_q[1] == clk_sync_q[2]) ? clk_sync_q[2] : clk_lvl_q;
    dir_lvl_d  = (dir_sync_q[1] == dir_sync_q[2]) ? dir_sync_q[2] : dir_lvl_q;
    // Edges compare the accepted level with its next value
    clk_rise   = clk_lvl_d & ~clk_lvl_q;
    clk_fall   = ~clk_lvl_d & clk_lvl_q;
    dir_rise   = dir_lvl_d & ~dir_lvl_q;
    dir_fall   = ~dir_lvl_d & dir_lvl_q;
  end

  // Synchroniser registers
  // Reset parks every stage low, matching the idle level of the pins
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      clk_sync_q <= 3'h0;
      dir_sync_q <= 3'h0;
      clk_lvl_q  <= 1'b0;
      dir_lvl_q  <= 1'b0;
    end
    else
    begin
      clk_sync_q <= clk_sync_d;
      dir_sync_q <= dir_sync_d;
      clk_lvl_q  <= clk_lvl_d;
      dir_lvl_q  <= dir_lvl_d;
    end
  end

  // Ramp sequencer next values
  // Triggers are decoded on every clock; ticks gate only steps and timeouts
  always_comb
  begin
    auto_mode = cfg.ramp_enable & ~cfg.pin_mode;
    seg       = seg_q ? seg1 : seg0;
    // Trigger edges act between halved ticks too, as triggers are not gated by tick
    trig_a    = trig_fire(cfg.trig_a_src, clk_rise, clk_fall, dir_rise, dir_fall);
    trig_b    = trig_fire(cfg.trig_b_src, clk_rise, clk_fall, dir_rise, dir_fall);
    tick      = ~cfg.clock_halve | phase_q;
    timeout   = tick & (count_q >= seg.length);
    advance   = event_sel(seg.advance, timeout, trig_a, trig_b);
    rpt_event = event_sel(cfg.repeat_event, advance, trig_a, trig_b);
    // Sign-extend the 30-bit increment before adding
    step_sum  = $signed(num_q) + $signed({{(NUM_W-INC_W){seg.increment[INC_W-1]}}, seg.increment});
    moved     = $signed(num_q) - $signed(cal_ref_q);
    abs_moved = moved[NUM_W-1] ? NUM_W'(-moved) : NUM_W'(moved);

    // Hold all but the halving toggle and calibration request unless a branch below says otherwise
    state_d   = state_q;
    seg_d     = seg_q;
    count_d   = count_q;
    rpt_d     = rpt_q;
    num_d     = num_q;
    origin_d  = origin_q;
    cal_ref_d = cal_ref_q;
    phase_d   = cfg.clock_halve ? ~phase_q : 1'b0;
    creq_d    = 1'b0;

    case (state_q)
      ST_IDLE:
      begin
        // Waiting for a start write; triggers and ticks are ignored here
        if (cal_start && auto_mode)
        begin
          // Start value is both restore point and calibration reference
          state_d   = ST_RUN;
          seg_d     = 1'b0;
          count_d   = LEN_ZERO;
          rpt_d     = RPT_ZERO;
          num_d     = start_numerator;
          origin_d  = start_numerator;
          cal_ref_d = start_numerator;
          phase_d   = 1'b0;
        end
      end
      ST_RUN:
      begin
        // Dropping the enable stops the ramp at once, numerator left as is
        if (!auto_mode)
          state_d = ST_IDLE;
        else
        begin
          if (advance)
          begin
            // A segment change takes the whole cycle; no increment is added
            seg_d   = seg.successor;
            count_d = LEN_ZERO;
            if (seg.restore)
              num_d = origin_q;
            if (cfg.cal_per_segment)
            begin
              state_d   = ST_CAL;
              cal_ref_d = num_d;
            end
          end
          else if (tick)
          begin
            // Ordinary step: add, clamp, count
            count_d = count_q + LEN_ONE;
            num_d   = clamp(step_sum, cfg.limit_low, cfg.limit_high);
            // Movement is measured before this step, so calibration may start one step late
            if (abs_moved >= cfg.cal_threshold)
            begin
              state_d   = ST_CAL;
              cal_ref_d = num_d;     // Reference is the value the calibration locks to
            end
          end
          // Repeat events count on their own, whatever the segment does
          if (rpt_event)
          begin
            rpt_d = rpt_q + RPT_ONE;
            // Zero repeat count runs without end; reaching the count overrides any calibration
            if (cfg.repeat_count != RPT_ZERO && rpt_d >= cfg.repeat_count)
              state_d = ST_IDLE;
          end
        end
      end
      ST_CAL:
      begin
        // Numerator and counter frozen until calibration ends
        creq_d = 1'b1;
        if (!auto_mode)
        begin
          // Leaving early withdraws the request at the same edge
          state_d = ST_IDLE;
          creq_d  = 1'b0;
        end
        // cal_done only counts once our own request is visible outside
        else if (cal_done && creq_q)
        begin
          state_d = ST_RUN;
          creq_d  = 1'b0;
        end
      end
      default:
        // Unused state code falls back to idle
        state_d = ST_IDLE;
    endcase
  end

  // Ramp sequencer registers
  // All state clears on reset; the numerator restarts from zero
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_q   <= ST_IDLE;
      seg_q     <= 1'b0;
      count_q   <= LEN_ZERO;
      rpt_q     <= RPT_ZERO;
      num_q     <= NUM_RESET;
      origin_q  <= NUM_RESET;
      cal_ref_q <= NUM_RESET;
      phase_q   <= 1'b0;
      creq_q    <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      seg_q     <= seg_d;
      count_q   <= count_d;
      rpt_q     <= rpt_d;
      num_q     <= num_d;
      origin_q  <= origin_d;
      cal_ref_q <= cal_ref_d;
      phase_q   <= phase_d;
      creq_q    <= creq_d;
    end
  end

  // Outputs straight from flip-flops
  // ramp_active decodes the state register and so adds no extra delay
  assign numerator       = num_q;
  assign ramp_active     = (state_q != ST_IDLE);
  assign current_segment = seg_q;
  assign cal_request     = creq_q;

endmodule : ramp_generator

//--- dv/ramp_monitor.sv
// Purpose: Port checker for the ramp generator.
// Assumes: One clock domain, synchronous reset.
// Notes:   Bound to every ramp_generator instance.
module ramp_monitor
(
  // Clock and reset
  input wire logic                          ref_clk,
  input wire logic                          reset,
  // Settings and requests
  input wire ramp_pkg::ramp_cfg_t           cfg,
  input wire ramp_pkg::segment_cfg_t        seg0,
  input wire ramp_pkg::segment_cfg_t        seg1,
  input wire logic [ramp_pkg::NUM_W-1:0]    start_numerator,
  input wire logic                          cal_start,
  input wire logic                          cal_done,
  // Outputs under watch
  input wire logic                          cal_request,
  input wire logic [ramp_pkg::NUM_W-1:0]    numerator,
  input wire logic                          ramp_active,
  input wire logic                          current_segment
);
  import ramp_pkg::*;
  logic        [INC_W-1:0] inc;  // Step of the active segment
  logic signed [NUM_W-1:0] nxt;  // Clamped numerator after one step

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Expected step, sign-extended and clamped
  always_comb
  begin
    inc = current_segment ? seg1.increment : seg0.increment;
    nxt = $signed(numerator) + $signed({{(NUM_W-INC_W){inc[INC_W-1]}}, inc});
    if (nxt > $signed(cfg.limit_high))
      nxt = cfg.limit_high;
    else if (nxt < $signed(cfg.limit_low))
      nxt = cfg.limit_low;
  end

  property p_start; !ramp_active && cal_start && cfg.ramp_enable && !cfg.pin_mode
    |=> ramp_active && numerator == start_numerator && !current_segment; endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_mode; !cfg.ramp_enable || cfg.pin_mode |=> !ramp_active; endproperty
  a_mode: assert property (p_mode) else $error("ran outside automatic mode");
  property p_hold; cal_request |=> $stable(numerator); endproperty
  a_hold: assert property (p_hold) else $error("numerator moved in calibration");
  property p_release; cal_request && cal_done |=> !cal_request; endproperty
  a_release: assert property (p_release) else $error("calibration not released");
  property p_step; $past(ramp_active && !cal_request) && ramp_active && !cal_request && !cfg.clock_halve
    && cfg.trig_a_src == TRG_OFF && cfg.trig_b_src == TRG_OFF && !$changed(current_segment)
    && (current_segment ? seg1.successor : seg0.successor) != current_segment
    |-> numerator == $past(nxt); endproperty
  a_step: assert property (p_step) else $error("wrong ramp step");
  property p_succ; $past(ramp_active) && ramp_active && $changed(current_segment)
    |-> current_segment == $past(current_segment ? seg1.successor : seg0.successor); endproperty
  a_succ: assert property (p_succ) else $error("wrong next segment");
  property p_restore; $past(ramp_active) && ramp_active && $changed(current_segment)
    && $past(current_segment ? seg1.restore : seg0.restore) |-> numerator == start_numerator; endproperty
  a_restore: assert property (p_restore) else $error("start value not restored");
  property p_halve; cfg.clock_halve && cfg.trig_a_src == TRG_OFF && cfg.trig_b_src == TRG_OFF
    && $past(ramp_active) && ramp_active && $changed(numerator) |=> $stable(numerator); endproperty
  a_halve: assert property (p_halve) else $error("step on two adjacent cycles");
endmodule : ramp_monitor

bind ramp_generator ramp_monitor u_mon (.ref_clk, .reset, .cfg, .seg0, .seg1, .start_numerator,
  .cal_start, .cal_done, .cal_request, .numerator, .ramp_active, .current_segment);

//--- dv/vco_cal_model.sv
// Purpose: Calibration engine standing at the generator's far side.
// Assumes: A calibration answers CAL_CYCLES+1 clocks after the request rises.
// Notes:   One done pulse per request; a slow value shows stretched calibrations.
module vco_cal_model #(parameter int CAL_CYCLES = 5)
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Calibration handshake
  input  wire logic cal_request,
  output logic      cal_done
);
  int busy_q;  // Clocks spent on the current calibration

  // Count while asked, answer once, forget when released
  always @(posedge ref_clk)
  begin
    if (reset || !cal_request)
      busy_q <= 0;
    else if (busy_q <= CAL_CYCLES)
      busy_q <= busy_q + 1;
    cal_done <= !reset && cal_request && busy_q == CAL_CYCLES;
  end
endmodule : vco_cal_model

//--- dv/ramp_generator_tb_top.sv
// Purpose: Self-checking bench for the ramp generator.
// Assumes: Inputs change 5 ns after each rising edge.
// Notes:   Expected ramps come from a cycle model inside the bench.
module ramp_generator_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ramp_pkg::*;
  logic             ref_clk            = 1'h0;
  logic             reset              = 1'h1;
  logic             cal_start          = 1'h0;
  logic             step_clock_pin     = 1'h0;
  logic             step_direction_pin = 1'h0;
  logic             cal_done, cal_request, ramp_active, current_segment;
  logic [NUM_W-1:0] numerator;
  logic [NUM_W-1:0] start_numerator    = 34'h64; // Against the fixed ramp denominator
  ramp_cfg_t        cfg = '{1'h1, 1'h0, 1'h0, 1'h0, TRG_OFF, TRG_OFF, RPT_ZERO, ADV_TIMEOUT,
                            34'h1FFFFFFFF, 34'h200000000, 34'h1FFFFFFFF};
  segment_cfg_t     seg0 = '{16'h0003, 30'h00000005, 1'h1, ADV_TIMEOUT, 1'h1};
  segment_cfg_t     seg1 = '{16'h0002, 30'h3FFFFFFD, 1'h0, ADV_TIMEOUT, 1'h0}; // Restore left clear
  int               mismatches, samples_checked;

  ramp_generator u_dut (.ref_clk, .reset, .cfg, .seg0, .seg1, .start_numerator, .cal_start,
    .step_clock_pin, .step_direction_pin, .cal_done, .cal_request, .numerator, .ramp_active,
    .current_segment);
  vco_cal_model u_cal (.ref_clk, .reset, .cal_request, .cal_done);

  always #25 ref_clk = !ref_clk;

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  task automatic check(input logic [NUM_W-1:0] seen, input logic [NUM_W-1:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask : tick

  task automatic go();
    cal_start = 1'h1;
    tick(1);
    cal_start = 1'h0;
  endtask : go

  task automatic stop();
    cfg.ramp_enable = 1'h0;
    tick(2);
    cfg.ramp_enable = 1'h1;
  endtask : stop

  // Bounded wait for a level on cal_request (which 0) or ramp_active (which 1)
  task automatic await(input bit which, input logic v);
    int   k;
    logic s;
    k = 0;
    s = which ? ramp_active : cal_request;
    while (s !== v && k < 40)
    begin
      tick(1);
      k++;
      s = which ? ramp_active : cal_request;
    end
    check(NUM_W'(s), NUM_W'(v));
    if (s !== v)
      results();
  endtask : await

  // Start is refused outside automatic mode
  task automatic refuse();
    cfg.ramp_enable = 1'h0;
    go();
    check(NUM_W'(ramp_active), NUM_W'(1'h0));
    cfg.ramp_enable = 1'h1;
    cfg.pin_mode = 1'h1;
    go();
    check(NUM_W'(ramp_active), NUM_W'(1'h0));
    cfg.pin_mode = 1'h0;
  endtask : refuse

  // Timeout-only ramp compared with a cycle model
  task automatic model(input int n);
    logic signed [NUM_W-1:0] num;
    logic                    sg;
    int                      cnt;
    segment_cfg_t            s;
    num = start_numerator;
    sg = 1'h0;
    cnt = 0;
    go();
    repeat (n)
    begin
      check(numerator, num);
      check(NUM_W'(current_segment), NUM_W'(sg));
      s = sg ? seg1 : seg0;
      if (cnt >= s.length)
      begin
        sg = s.successor;
        cnt = 0;
        num = s.restore ? start_numerator : num;
      end
      else
      begin
        num = num + $signed({{(NUM_W-INC_W){s.increment[INC_W-1]}}, s.increment});
        num = (num > $signed(cfg.limit_high)) ? cfg.limit_high : num;
        num = (num < $signed(cfg.limit_low)) ? cfg.limit_low : num;
        cnt++;
      end
      tick(1);
    end
    stop();
  endtask : model

  // Sawtooth, clamped sawtooth and halved clock
  task automatic sawtooth();
    model(20);
    cfg.limit_high = 34'h6E;
    cfg.limit_low = 34'h5F;
    model(15);
    cfg.limit_high = 34'h1FFFFFFFF;
    cfg.limit_low = 34'h200000000;
    cfg.clock_halve = 1'h1;
    go();
    tick(2);
    check(numerator, 34'h69);
    tick(20);
    stop();
    cfg.clock_halve = 1'h0;
  endtask : sawtooth

  // Every pin edge source advances on trigger A, then always-on trigger B
  task automatic trig();
    logic [3:0] c[4] = '{TRG_CLK_RISE, TRG_DIR_RISE, TRG_CLK_FALL, TRG_DIR_FALL};
    logic       x;
    seg0.advance = ADV_TRIG_A;
    seg1.advance = ADV_TRIG_A;
    foreach (c[i])
    begin
      cfg.trig_a_src = c[i];
      step_clock_pin = c[i][3];
      step_direction_pin = c[i][3];
      tick(6);
      go();
      tick(8);
      check(NUM_W'(current_segment), NUM_W'(1'h0));
      if (c[i][1])
        step_direction_pin = !c[i][3];
      else
        step_clock_pin = !c[i][3];
      tick(8);
      check(NUM_W'(current_segment), NUM_W'(1'h1));
      stop();
    end
    cfg.trig_a_src = TRG_OFF;
    cfg.trig_b_src = TRG_ALWAYS;
    seg0.advance = ADV_TRIG_B;
    seg1.advance = ADV_TRIG_B;
    go();
    tick(3);
    x = current_segment;
    tick(1);
    check(NUM_W'(current_segment), NUM_W'(!x));
    stop();
    cfg.trig_b_src = TRG_OFF;
    seg0.advance = ADV_TIMEOUT;
    seg1.advance = ADV_TIMEOUT;
  endtask : trig

  // Threshold and per-segment recalibration
  task automatic cal();
    cfg.cal_threshold = 34'h8; // Small steps keep the slew low
    go();
    await(1'b0, 1'h1);
    await(1'b0, 1'h0);
    stop();
    cfg.cal_threshold = 34'h1FFFFFFFF;
    cfg.cal_per_segment = 1'h1;
    go();
    await(1'b0, 1'h1);
    stop();
    cfg.cal_per_segment = 1'h0;
  endtask : cal

  // Terminating pattern stops after its repeat count, counted on transitions, then on trigger B
  task automatic rpt();
    cfg.repeat_count = 13'h2;
    go();
    check(NUM_W'(ramp_active), NUM_W'(1'h1));
    await(1'b1, 1'h0);
    cfg.repeat_count = 13'h3;
    cfg.repeat_event = ADV_TRIG_B;
    cfg.trig_b_src = TRG_ALWAYS;
    go();
    tick(2);
    check(NUM_W'(ramp_active), NUM_W'(1'h1));
    tick(1);
    check(NUM_W'(ramp_active), NUM_W'(1'h0));
    cfg.trig_b_src = TRG_OFF;
    cfg.repeat_event = ADV_TIMEOUT;
    cfg.repeat_count = RPT_ZERO;
  endtask : rpt

  initial
  begin
    tick(16);
    reset = 1'h0;
    refuse();
    sawtooth();
    trig();
    cal();
    rpt();
    results();
  end
endmodule : ramp_generator_tb_top
